// ### ebh_bus_port.sv
// Function
// - dram access in hold on select low, or a flush when hold ends
// - completion low marks dram access finished
// - hold floats bus pins, grant driven low
// - hold data driven only select low, read
// - hold completion driven only while select low
// - reads and word writes both lanes low, half writes chosen lanes
// - wait until completion sampled low
// - idle cycle between read then write
// - burst on aligned word or instruction line
// - burst low first cycle, high on last
// - word read: high half then low half
// - cache refill: eight cycles, wrap in line
// - non-cache fetch: run to line end
// - word write burst, high half first
// - hold request low enters hold, high leaves
// - hold read presents 16 bits, then completion
// - read fills 128-bit buffer, hits take one
// - started access not cancelled, inputs stable
// - hold write merges strobed bytes in buffer
`timescale 1ns/10ps
`default_nettype none
module ebh_bus_port #(
  parameter int ADDR_W = ebh_pkg::ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // internal master request
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire ebh_pkg::ebh_kind_t i_req_kind,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [1:0] i_req_be,
  input wire logic [31:0] i_req_wdata,
  input wire logic i_req_io,
  input wire logic i_icache_mode,
  output logic o_rd_valid,
  output logic [ebh_pkg::DATA_W-1:0] o_rd_data,
  output logic o_done,
  // external bus pins
  input wire logic [ADDR_W-1:0] i_ext_address,
  output logic [ADDR_W-1:0] o_ext_address,
  output logic o_ext_address_oe,
  input wire logic [ebh_pkg::DATA_W-1:0] i_ext_data,
  output logic [ebh_pkg::DATA_W-1:0] o_ext_data,
  output logic o_ext_data_oe,
  input wire logic i_byte_lane_high_n,
  input wire logic i_byte_lane_low_n,
  output logic o_byte_lane_high_n,
  output logic o_byte_lane_low_n,
  output logic o_byte_lane_oe,
  input wire logic i_read_write,
  output logic o_read_write,
  output logic o_read_write_oe,
  output logic o_space_identifier,
  output logic o_fetch_status,
  output logic o_cycle_begin_n,
  output logic o_burst_n,
  output logic o_ctrl_oe,
  input wire logic i_cycle_complete_n,
  output logic o_cycle_complete_n,
  output logic o_cycle_complete_oe,
  input wire logic i_hold_request_n,
  output logic o_hold_grant_n,
  input wire logic i_dram_select_n,
  // internal dram port
  output logic o_dram_req,
  output logic o_dram_write,
  output logic [ADDR_W-ebh_pkg::IDX_W-1:0] o_dram_block,
  output logic [ebh_pkg::LINE_W-1:0] o_dram_wdata,
  input wire logic i_dram_ack,
  input wire logic [ebh_pkg::LINE_W-1:0] i_dram_rdata
);
  localparam int TAG_W = ADDR_W - ebh_pkg::IDX_W;
  localparam int DW = ebh_pkg::DATA_W;
  localparam int BW = ebh_pkg::BYTE_W;

  ////////////////////////////////////////////////////////////////////////////
  ebh_pkg::ebh_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [3:0] left_reg, left_next;
  logic write_reg, write_next;
  logic [1:0] lanes_reg, lanes_next;
  logic [31:0] wdata_reg, wdata_next;
  logic sid_reg, sid_next;
  logic fetch_reg, fetch_next;
  logic last_read_reg, last_read_next;
  logic bs_n_reg, bs_n_next;
  logic burst_n_reg, burst_n_next;
  logic rd_valid_reg, rd_valid_next;
  logic [DW-1:0] rd_data_reg, rd_data_next;
  logic done_reg, done_next;
  logic [DW-1:0] dout_reg, dout_next;
  logic [TAG_W-1:0] tag_reg, tag_next;
  logic bvalid_reg, bvalid_next;
  logic dirty_reg, dirty_next;
  logic [DW-1:0] buf_reg [ebh_pkg::LINE_HW];
  logic [DW-1:0] buf_next [ebh_pkg::LINE_HW];
  logic in_hold;
  logic hit;
  logic [ebh_pkg::IDX_W-1:0] in_idx;

  // decode of the hold-side access
  assign in_idx = i_ext_address[ebh_pkg::IDX_W-1:0];
  assign hit = bvalid_reg && (tag_reg == i_ext_address[ADDR_W-1:ebh_pkg::IDX_W]);
  assign in_hold = (state_reg == ebh_pkg::EBH_HOLD) || (state_reg == ebh_pkg::EBH_FLUSH) ||
                   (state_reg == ebh_pkg::EBH_FILL) || (state_reg == ebh_pkg::EBH_ANSWER) ||
                   (state_reg == ebh_pkg::EBH_RELEASE);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for master cycles and the hold-side buffer
  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    write_next = write_reg;
    lanes_next = lanes_reg;
    wdata_next = wdata_reg;
    sid_next = sid_reg;
    fetch_next = fetch_reg;
    last_read_next = last_read_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    done_next = 1'b0;
    dout_next = dout_reg;
    tag_next = tag_reg;
    bvalid_next = bvalid_reg;
    dirty_next = dirty_reg;
    buf_next = buf_reg;
    unique case (state_reg)
      ebh_pkg::EBH_IDLE:
      begin
        if (!i_hold_request_n)
        begin
          state_next = ebh_pkg::EBH_HOLD;
        end
        else if (i_req_valid)
        begin
          addr_next = i_req_addr;
          write_next = i_req_write;
          sid_next = i_req_io;
          fetch_next = (i_req_kind != ebh_pkg::EBH_KIND_FETCH);
          lanes_next = i_req_write ? ~i_req_be : ebh_pkg::LANES_ALL;
          wdata_next = (i_req_kind == ebh_pkg::EBH_KIND_WORD) ? i_req_wdata
                       : {i_req_wdata[DW-1:0], ebh_pkg::DATA_RST};
          if (i_req_kind == ebh_pkg::EBH_KIND_WORD)
          begin
            lanes_next = ebh_pkg::LANES_ALL;
            left_next = ebh_pkg::CYC_WORD;
          end
          else if (i_req_kind == ebh_pkg::EBH_KIND_FETCH)
          begin
            // refill wraps in the line, a plain fetch stops at its end
            left_next = i_icache_mode ? ebh_pkg::CYC_LINE
                        : 4'(ebh_pkg::LINE_END - i_req_addr[ebh_pkg::IDX_W-1:0]) + ebh_pkg::CYC_ONE;
          end
          else
          begin
            left_next = ebh_pkg::CYC_HALF;
          end
          state_next = (i_req_write && last_read_reg) ? ebh_pkg::EBH_TURN : ebh_pkg::EBH_START;
        end
      end
      ebh_pkg::EBH_TURN:
      begin
        last_read_next = 1'b0;
        state_next = ebh_pkg::EBH_START;
      end
      ebh_pkg::EBH_START:
      begin
        dout_next = wdata_reg[31:DW];
        state_next = ebh_pkg::EBH_WAIT;
      end
      ebh_pkg::EBH_WAIT:
      begin
        if (!i_cycle_complete_n)
        begin
          last_read_next = !write_reg;
          rd_valid_next = !write_reg;
          rd_data_next = i_ext_data;
          if (left_reg > ebh_pkg::CYC_ONE)
          begin
            left_next = left_reg - ebh_pkg::CYC_ONE;
            addr_next[ebh_pkg::IDX_W-1:0] = addr_reg[ebh_pkg::IDX_W-1:0] + ebh_pkg::IDX_STEP;
            wdata_next = {wdata_reg[DW-1:0], ebh_pkg::DATA_RST};
            state_next = ebh_pkg::EBH_START;
          end
          else
          begin
            done_next = 1'b1;
            state_next = ebh_pkg::EBH_IDLE;
          end
        end
      end
      ebh_pkg::EBH_HOLD:
      begin
        if (!i_dram_select_n)
        begin
          if (hit)
          begin
            dout_next = buf_reg[in_idx];
            if (!i_read_write)
            begin
              // strobed bytes land in the buffer, flushed later
              if (!i_byte_lane_high_n)
              begin
                buf_next[in_idx][DW-1:BW] = i_ext_data[DW-1:BW];
              end
              if (!i_byte_lane_low_n)
              begin
                buf_next[in_idx][BW-1:0] = i_ext_data[BW-1:0];
              end
              dirty_next = 1'b1;
            end
            state_next = ebh_pkg::EBH_ANSWER;
          end
          else
          begin
            state_next = dirty_reg ? ebh_pkg::EBH_FLUSH : ebh_pkg::EBH_FILL;
          end
        end
        else if (i_hold_request_n)
        begin
          state_next = dirty_reg ? ebh_pkg::EBH_FLUSH : ebh_pkg::EBH_IDLE;
        end
      end
      ebh_pkg::EBH_FLUSH:
      begin
        if (i_dram_ack)
        begin
          dirty_next = 1'b0;
          state_next = ebh_pkg::EBH_HOLD;
        end
      end
      ebh_pkg::EBH_FILL:
      begin
        if (i_dram_ack)
        begin
          for (int i = 0; i < ebh_pkg::LINE_HW; i++)
          begin
            buf_next[i] = i_dram_rdata[i*DW +: DW];
          end
          tag_next = i_ext_address[ADDR_W-1:ebh_pkg::IDX_W];
          bvalid_next = 1'b1;
          state_next = ebh_pkg::EBH_HOLD;
        end
      end
      ebh_pkg::EBH_ANSWER:
      begin
        state_next = ebh_pkg::EBH_RELEASE;
      end
      ebh_pkg::EBH_RELEASE:
      begin
        if (i_dram_select_n)
        begin
          state_next = ebh_pkg::EBH_HOLD;
        end
      end
    endcase
  end

  // cycle strobes follow the next state so they line up with it
  assign bs_n_next = (state_next != ebh_pkg::EBH_START);
  assign burst_n_next = !(((state_next == ebh_pkg::EBH_START) || (state_next == ebh_pkg::EBH_WAIT))
                          && (left_next > ebh_pkg::CYC_ONE));

  ////////////////////////////////////////////////////////////////////////////
  // register stage
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      state_reg <= ebh_pkg::EBH_IDLE;
      addr_reg <= ebh_pkg::ADDR_RST;
      left_reg <= ebh_pkg::CYC_ONE;
      write_reg <= 1'b0;
      lanes_reg <= ebh_pkg::LANES_OFF;
      wdata_reg <= ebh_pkg::WDATA_RST;
      sid_reg <= 1'b0;
      fetch_reg <= 1'b1;
      last_read_reg <= 1'b0;
      bs_n_reg <= 1'b1;
      burst_n_reg <= 1'b1;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= ebh_pkg::DATA_RST;
      done_reg <= 1'b0;
      dout_reg <= ebh_pkg::DATA_RST;
      tag_reg <= '0;
      bvalid_reg <= 1'b0;
      dirty_reg <= 1'b0;
      for (int i = 0; i < ebh_pkg::LINE_HW; i++)
      begin
        buf_reg[i] <= ebh_pkg::DATA_RST;
      end
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      write_reg <= write_next;
      lanes_reg <= lanes_next;
      wdata_reg <= wdata_next;
      sid_reg <= sid_next;
      fetch_reg <= fetch_next;
      last_read_reg <= last_read_next;
      bs_n_reg <= bs_n_next;
      burst_n_reg <= burst_n_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      done_reg <= done_next;
      dout_reg <= dout_next;
      tag_reg <= tag_next;
      bvalid_reg <= bvalid_next;
      dirty_reg <= dirty_next;
      buf_reg <= buf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: hold floats the bus, hands data and completion to select
  assign o_req_ready = (state_reg == ebh_pkg::EBH_IDLE) && i_hold_request_n;
  assign o_rd_valid = rd_valid_reg;
  assign o_rd_data = rd_data_reg;
  assign o_done = done_reg;
  assign o_ext_address = addr_reg;
  assign o_ext_address_oe = !in_hold;
  assign o_byte_lane_high_n = lanes_reg[1];
  assign o_byte_lane_low_n = lanes_reg[0];
  assign o_byte_lane_oe = !in_hold;
  assign o_read_write = !write_reg;
  assign o_read_write_oe = !in_hold;
  assign o_space_identifier = sid_reg;
  assign o_fetch_status = fetch_reg;
  assign o_cycle_begin_n = bs_n_reg;
  assign o_burst_n = burst_n_reg;
  assign o_ctrl_oe = !in_hold;
  assign o_ext_data = dout_reg;
  assign o_ext_data_oe = in_hold ? (!i_dram_select_n && i_read_write)
                         : (write_reg && ((state_reg == ebh_pkg::EBH_START) || (state_reg == ebh_pkg::EBH_WAIT)));
  assign o_cycle_complete_n = (state_reg != ebh_pkg::EBH_ANSWER);
  assign o_cycle_complete_oe = in_hold && !i_dram_select_n;
  assign o_hold_grant_n = !in_hold;
  assign o_dram_req = (state_reg == ebh_pkg::EBH_FLUSH) || (state_reg == ebh_pkg::EBH_FILL);
  assign o_dram_write = (state_reg == ebh_pkg::EBH_FLUSH);
  assign o_dram_block = (state_reg == ebh_pkg::EBH_FLUSH) ? tag_reg : i_ext_address[ADDR_W-1:ebh_pkg::IDX_W];

  // buffer flattened onto the dram write bus, entry 0 lowest
  for (genvar g = 0; g < ebh_pkg::LINE_HW; g++)
  begin : g_flat
    assign o_dram_wdata[g*DW +: DW] = buf_reg[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  hold_float_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !o_hold_grant_n |-> !o_ext_address_oe && !o_ctrl_oe && !o_byte_lane_oe && !o_read_write_oe)
    else $error("bus pins driven during hold");
  data_drive_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!o_hold_grant_n && o_ext_data_oe) |-> (!i_dram_select_n && i_read_write))
    else $error("data driven in hold without select read");
  done_drive_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!o_hold_grant_n && i_dram_select_n) |-> !o_cycle_complete_oe)
    else $error("completion driven without select");
  read_lanes_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!o_cycle_begin_n && o_read_write) |-> (!o_byte_lane_high_n && !o_byte_lane_low_n))
    else $error("read with a byte lane high");
  wait_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state_reg == ebh_pkg::EBH_WAIT && i_cycle_complete_n) |=> o_cycle_begin_n && state_reg == ebh_pkg::EBH_WAIT)
    else $error("cycle left before completion");
  turn_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_req_ready && i_req_valid && i_req_write && last_read_reg) |=> o_cycle_begin_n ##1 !o_cycle_begin_n)
    else $error("no idle cycle after read");
  burst_last_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!o_cycle_begin_n && left_reg == ebh_pkg::CYC_ONE) |-> o_burst_n)
    else $error("burst low on last cycle");
  hit_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state_reg == ebh_pkg::EBH_HOLD && !i_dram_select_n && hit) |=> !o_cycle_complete_n)
    else $error("buffer hit not answered in one cycle");
  grant_mid_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state_reg == ebh_pkg::EBH_WAIT) |=> o_hold_grant_n)
    else $error("hold granted inside a bus cycle");
endmodule : ebh_bus_port
`default_nettype wire

// ### ebh_pkg.sv
`default_nettype none
package ebh_pkg;
  // pin and bus widths
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int LINE_HW = 8;
  localparam int IDX_W = 3;
  localparam int LINE_W = 128;
  localparam int BYTE_W = 8;
  // burst lengths in bus cycles
  localparam logic [3:0] CYC_HALF = 4'h1;
  localparam logic [3:0] CYC_WORD = 4'h2;
  localparam logic [3:0] CYC_LINE = 4'h8;
  localparam logic [3:0] CYC_ONE = 4'h1;
  // halfword index of the line end
  localparam logic [IDX_W-1:0] LINE_END = 3'h7;
  localparam logic [IDX_W-1:0] IDX_STEP = 3'h1;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [31:0] WDATA_RST = 32'h00000000;
  localparam logic [1:0] LANES_OFF = 2'h3;
  localparam logic [1:0] LANES_ALL = 2'h0;
  // kind of internal request
  typedef enum logic [1:0] {EBH_KIND_HALF, EBH_KIND_WORD, EBH_KIND_FETCH} ebh_kind_t;
  // port sequencer states
  typedef enum logic [3:0] {
    EBH_IDLE, EBH_TURN, EBH_START, EBH_WAIT,
    EBH_HOLD, EBH_FLUSH, EBH_FILL, EBH_ANSWER, EBH_RELEASE
  } ebh_state_t;
endpackage : ebh_pkg
`default_nettype wire

// ### ebh_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
// far-side peripheral: answers each bus cycle after a set number of waits
module ebh_periph_model (
  input wire logic i_clk,
  input wire logic i_begin_n,
  input wire logic i_ctrl_oe,
  input wire logic [22:0] i_addr,
  input wire logic i_rw,
  input wire logic [1:0] i_wait,
  input wire logic [15:0] i_wdata,
  output logic o_complete_n,
  output logic [15:0] o_data,
  output logic o_wr_pulse,
  output logic [15:0] o_wr_data
);
  logic busy_reg = 1'b0;
  logic rw_reg = 1'b1;
  logic [1:0] cnt_reg = 2'h0;
  logic [22:0] addr_reg = 23'h000000;
  logic [15:0] last_reg = 16'h0000;
  // cycle tracking on the falling edge, away from the sampling edge
  always @(negedge i_clk)
  begin
    o_wr_pulse <= 1'b0;
    last_reg <= o_data;
    if (busy_reg)
    begin
      if (cnt_reg == 2'h0)
      begin
        busy_reg <= 1'b0;
        o_wr_pulse <= !rw_reg;
        o_wr_data <= i_wdata;
      end
      else
        cnt_reg <= cnt_reg - 2'h1;
    end
    if (!i_begin_n && i_ctrl_oe)
    begin
      busy_reg <= 1'b1;
      // one extra count so completion spans the sampling edge of the wait state
      cnt_reg <= i_wait + 2'h1;
      addr_reg <= i_addr;
      rw_reg <= i_rw;
    end
  end
  // completion low for one cycle once the waits have run out
  assign o_complete_n = !(busy_reg && cnt_reg == 2'h0);
  // read data while a read is open, otherwise a pattern that keeps changing
  assign o_data = (busy_reg && rw_reg) ? (addr_reg[15:0] ^ 16'h5A3C) : ~last_reg;
endmodule : ebh_periph_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic [22:0] a; logic rw; logic [1:0] ln; logic bn; logic fs; logic space_identifier; logic [15:0] d;} ebh_exp_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rq_v = 1'b0, rq_w = 1'b0, rq_io = 1'b0, icm = 1'b0, dack = 1'b0;
  logic hold_request_n_n = 1'b1, sel_n = 1'b1, tb_rw = 1'b1;
  ebh_pkg::ebh_kind_t rq_k = ebh_pkg::EBH_KIND_HALF;
  logic [22:0] rq_a = 23'h000000, tb_a = 23'h000000;
  logic [1:0] rq_be = 2'h3, tb_ln = 2'h3, pw = 2'h0;
  logic [31:0] rq_d = 32'h00000000;
  logic [15:0] tb_d = 16'h0000;
  logic [127:0] drd = 128'h0;
  logic rdy, rdv, done, a_oe, d_oe, ln_oe, rw_o, rw_oe, space_identifier, fst, bs_n, bu_n, ctl_oe, c_oe, c_o, grant_n;
  logic dreq, dwr, lh, ll, p_c, p_wp;
  logic [15:0] rdd, d_o, p_d, p_wd;
  logic [22:0] a_o;
  logic [19:0] dblk;
  logic [127:0] dwd;
  logic [127:0] dmem [logic [19:0]];
  logic [15:0] shw [logic [22:0]];
  ebh_exp_t expq[$], wrq[$], me, we;
  logic [22:0] rdq[$], ra;
  int fail_count = 0, checks_done = 0, cyc = 0, lst = -100, dcnt = 0;
  logic [1:0] lwt = 2'h0;
  logic lrw = 1'b0;
  wire [22:0] a_in = a_oe ? a_o : tb_a;
  wire [15:0] d_in = d_oe ? d_o : (grant_n ? p_d : tb_d);
  wire c_in = c_oe ? c_o : p_c;
  ebh_bus_port uut (.i_ref_clk(clk), .i_rstn(rstn), .i_req_valid(rq_v), .o_req_ready(rdy), .i_req_write(rq_w),
    .i_req_kind(rq_k), .i_req_addr(rq_a), .i_req_be(rq_be), .i_req_wdata(rq_d), .i_req_io(rq_io),
    .i_icache_mode(icm), .o_rd_valid(rdv), .o_rd_data(rdd), .o_done(done), .i_ext_address(a_in),
    .o_ext_address(a_o), .o_ext_address_oe(a_oe), .i_ext_data(d_in), .o_ext_data(d_o), .o_ext_data_oe(d_oe),
    .i_byte_lane_high_n(ln_oe ? lh : tb_ln[1]), .i_byte_lane_low_n(ln_oe ? ll : tb_ln[0]),
    .o_byte_lane_high_n(lh), .o_byte_lane_low_n(ll), .o_byte_lane_oe(ln_oe), .i_read_write(rw_oe ? rw_o : tb_rw),
    .o_read_write(rw_o), .o_read_write_oe(rw_oe), .o_space_identifier(space_identifier), .o_fetch_status(fst),
    .o_cycle_begin_n(bs_n), .o_burst_n(bu_n), .o_ctrl_oe(ctl_oe), .i_cycle_complete_n(c_in),
    .o_cycle_complete_n(c_o), .o_cycle_complete_oe(c_oe), .i_hold_request_n(hold_request_n_n), .o_hold_grant_n(grant_n),
    .i_dram_select_n(sel_n), .o_dram_req(dreq), .o_dram_write(dwr), .o_dram_block(dblk), .o_dram_wdata(dwd),
    .i_dram_ack(dack), .i_dram_rdata(drd));
  ebh_periph_model peer (.i_clk(clk), .i_begin_n(bs_n), .i_ctrl_oe(ctl_oe), .i_addr(a_o), .i_rw(rw_o),
    .i_wait(pw), .i_wdata(d_o), .o_complete_n(p_c), .o_data(p_d), .o_wr_pulse(p_wp), .o_wr_data(p_wd));
  ////////////////////////////////////////////////////////////
  // comparison, verdict and expected memory contents
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  function automatic logic [15:0] ihw(input logic [22:0] a);
    return a[15:0] ^ 16'hC3A5;
  endfunction : ihw
  function automatic logic [15:0] shget(input logic [22:0] a);
    return shw.exists(a) ? shw[a] : ihw(a);
  endfunction : shget
  function automatic logic [127:0] dget(input logic [19:0] b);
    logic [127:0] v;
    if (dmem.exists(b))
      return dmem[b];
    for (int i = 0; i < 8; i++)
      v[16*i +: 16] = ihw({b, 3'(i)});
    return v;
  endfunction : dget
  ////////////////////////////////////////////////////////////
  // clock, watchdog and internal memory with random latency
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  always @(negedge clk)
  begin
    dack <= 1'b0;
    if (dcnt != 0)
    begin
      dcnt <= dcnt - 1;
      if (dcnt == 1)
      begin
        dack <= 1'b1;
        if (dwr)
          dmem[dblk] = dwd;
        drd <= dget(dblk);
      end
    end
    else if (dreq === 1'b1 && !dack)
      dcnt <= 1 + $urandom % 4;
  end
  // bus cycle monitor: each start is matched against the expected sequence
  always @(negedge clk)
  begin
    cyc++;
    if (bs_n === 1'b0 && ctl_oe === 1'b1)
    begin
      check(expq.size() > 0, 1);
      me = expq.pop_front();
      check(a_o, me.a);
      check({rw_o, lh, ll}, {me.rw, me.ln});
      check(bu_n, me.bn);
      check({fst, space_identifier}, {me.fs, me.space_identifier});
      check(cyc - lst >= 2 + lwt + (!me.rw && lrw), 1);
      lst = cyc;
      lwt = pw;
      lrw = me.rw;
      if (me.rw)
        rdq.push_back(me.a);
      else
        wrq.push_back(me);
    end
    if (rdv === 1'b1)
    begin
      ra = rdq.pop_front();
      check(rdd, ra[15:0] ^ 16'h5A3C);
    end
    if (p_wp === 1'b1)
    begin
      we = wrq.pop_front();
      check(p_wd & {{8{!we.ln[1]}}, {8{!we.ln[0]}}}, we.d & {{8{!we.ln[1]}}, {8{!we.ln[0]}}});
    end
  end
  ////////////////////////////////////////////////////////////
  // one internal request: kind 0 half, 1 word, 2 fetch
  task automatic issue(input int k, input logic w, input logic [22:0] a, input logic [1:0] be, input logic ic,
    input logic hm);
    int n;
    int j;
    ebh_exp_t e;
    n = (k == 0) ? 1 : (k == 1) ? 2 : (ic ? 8 : 8 - int'(a[2:0]));
    @(negedge clk);
    rq_k = ebh_pkg::ebh_kind_t'(k);
    rq_w = w;
    rq_a = a;
    rq_be = be;
    rq_d = $urandom;
    rq_io = $urandom % 2;
    icm = ic;
    pw = 2'($urandom % 3);
    for (int i = 0; i < n; i++)
    begin
      e.a = {a[22:3], a[2:0] + 3'(i)};
      e.rw = !w;
      e.ln = (w && k == 0) ? ~be : 2'h0;
      e.bn = (i == n - 1);
      e.fs = (k != 2);
      e.space_identifier = rq_io;
      e.d = (k == 1 && i == 0) ? rq_d[31:16] : rq_d[15:0];
      expq.push_back(e);
    end
    rq_v = 1'b1;
    for (j = 0; j < 50 && rdy !== 1'b1; j++) @(negedge clk);
    @(negedge clk);
    rq_v = 1'b0;
    hold_request_n_n = !hm;
    for (j = 0; j < 300 && done !== 1'b1; j++)
    begin
      if (hm)
        check(grant_n, 1);
      @(negedge clk);
    end
    check(done, 1);
  endtask : issue
  // one outside access to the internal memory while in hold
  task automatic acc(input logic w, input logic [22:0] a, input logic [1:0] ln, input logic hit);
    int k;
    logic [15:0] v;
    @(negedge clk);
    sel_n = 1'b0;
    tb_rw = !w;
    tb_a = a;
    tb_ln = ln;
    tb_d = $urandom;
    for (k = 1; k < 60; k++)
    begin
      @(negedge clk);
      if (c_oe === 1'b1 && c_o === 1'b0)
        break;
    end
    if (hit)
      check(k, 1);
    else
      check(k > 1 && k < 60, 1);
    check(d_oe, !w);
    v = shget(a);
    if (!w)
      check(d_o, v);
    if (w && !ln[1])
      v[15:8] = tb_d[15:8];
    if (w && !ln[0])
      v[7:0] = tb_d[7:0];
    shw[a] = v;
    @(negedge clk);
    sel_n = 1'b1;
    @(negedge clk);
    check({c_oe, d_oe}, 0);
  endtask : acc
  task automatic wait_grant(input logic lvl);
    for (int j = 0; j < 200 && grant_n !== lvl; j++) @(negedge clk);
    check(grant_n, lvl);
  endtask : wait_grant
  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int k;
    logic [22:0] a;
    logic [22:0] b;
    k = $urandom(32'hF525A3BB);
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check({grant_n, d_oe, c_oe, bs_n, bu_n, a_oe}, 6'h27);
    sel_n = 1'b0;
    repeat (3) @(negedge clk);
    check({c_oe, dreq}, 0);
    sel_n = 1'b1;
    issue(1, 0, 23'h000102, 2'h0, 0, 0);
    issue(1, 1, 23'h000104, 2'h0, 0, 0);
    issue(2, 0, 23'h000106, 2'h0, 0, 0);
    issue(2, 0, 23'h00010C, 2'h0, 1, 0);
    issue(0, 1, 23'h000111, 2'h1, 0, 0);
    repeat (40)
    begin
      k = $urandom % 3;
      a = 23'($urandom);
      if (k != 0)
        a[0] = 1'b0;
      issue(k, k != 2 && $urandom % 2, a, 2'(1 + $urandom % 3), $urandom % 2, 0);
    end
    issue(0, 0, 23'h000200, 2'h0, 0, 1);
    wait_grant(1'b0);
    check({a_oe, ctl_oe, ln_oe, rw_oe, d_oe, c_oe}, 0);
    a = 23'($urandom);
    a[2:0] = 3'h2;
    b = a ^ 23'h000400;
    acc(1, a, 2'h1, 0);
    acc(0, a, 2'h0, 1);
    acc(1, a + 23'h1, 2'h2, 1);
    acc(0, a + 23'h1, 2'h0, 1);
    acc(0, b, 2'h0, 0);
    acc(0, a, 2'h0, 0);
    // buffer holds the block of a here, so b misses
    acc(1, b, 2'h0, 0);
    hold_request_n_n = 1'b1;
    wait_grant(1'b1);
    hold_request_n_n = 1'b0;
    wait_grant(1'b0);
    // buffer still holds b: read a first so b must come back from the flushed memory
    acc(0, a, 2'h3, 0);
    acc(0, b, 2'h3, 0);
    hold_request_n_n = 1'b1;
    wait_grant(1'b1);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
